// File: pkg/tls_pkg.sv
// Operation
// - Analog function codes 10, 11, 12 and 15 set positive, negative, regenerative and both torque limits, only in vector methods.
// - The forward limit applies whenever the demand produces forward torque, regenerating or not.
// - Four torque limit constants cover forward drive, reverse drive, forward regen and reverse regen by quadrant.
// - An analog torque limit equals full-scale input times the terminal gain, as percent of rated torque.
// - Channel one defaults to a 4 to 20 mA input and channel two to a 0 to 10 V input.
// - While a torque limit clamps, speed control and speed compensation are suspended.
// - Running stall prevention works only in V/f and V/f with encoder methods.
// - Current above the stall level for 100 ms continuously starts deceleration at the selected time.
// - Current at or below stall level minus 2% resumes acceleration at the set time.
// - Stall select 0 disables, 1 picks decel time one, 2 picks decel time two; reset value is 1.
// - Stall level is 30 to 200 percent of rated current, default 160, used only for select 1 or 2.
// - An analog channel with function 8 supplies a stall level after its gain and bias.
// - With an analog stall level, the smaller of analog and constant levels is used.
// - Torque limit accuracy is 5% at 10 Hz and above, looser below.
package tls_pkg;

  // ==========================================================================
  // Codes and constants
  localparam logic [4:0]  FN_STALL_LVL   = 5'h08;
  localparam logic [4:0]  FN_POS_TQ      = 5'h0A;
  localparam logic [4:0]  FN_NEG_TQ      = 5'h0B;
  localparam logic [4:0]  FN_REGEN_TQ    = 5'h0C;
  localparam logic [4:0]  FN_BOTH_TQ     = 5'h0F;
  localparam logic [1:0]  SEL_RESET      = 2'h1;
  localparam logic [9:0]  LVL_RESET      = 10'h0A0;    // 160 percent
  localparam logic [9:0]  LVL_MIN        = 10'h01E;    // 30 percent
  localparam logic [9:0]  LVL_MAX        = 10'h0C8;    // 200 percent
  localparam logic [9:0]  HYST_PCT       = 10'h002;    // 2 percent
  localparam logic [9:0]  TQ_FULL        = 10'h3FF;
  localparam logic [1:0]  CH1_MODE_RESET = 2'h1;       // 4 to 20 mA
  localparam logic [1:0]  CH2_MODE_RESET = 2'h0;       // 0 to 10 V
  localparam int          CLK_HZ         = 10000000;
  localparam int          STALL_MS       = 100;
  localparam int          STALL_CYC      = (CLK_HZ / 1000) * STALL_MS;
  localparam int          ADC_FS         = 4095;       // Full scale, 12 bit

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    TLS_VF      = 3'b000,
    TLS_VF_PG   = 3'b001,
    TLS_OLV1    = 3'b010,
    TLS_FLUX    = 3'b011,
    TLS_OLV2    = 3'b100
  } tls_method_t;

  typedef enum logic [1:0] {
    TLS_ST_RUN   = 2'b00,
    TLS_ST_DECEL = 2'b01,
    TLS_ST_ACCEL = 2'b10
  } tls_state_t;

  typedef struct packed {
    logic [4:0]  func;
    logic [9:0]  gain;    // Percent, tenths ignored
    logic [9:0]  bias;    // Percent
    logic [11:0] value;   // Raw sample
  } tls_ain_t;

  typedef struct packed {
    logic [9:0] fwd_drive;
    logic [9:0] rev_drive;
    logic [9:0] fwd_regen;
    logic [9:0] rev_regen;
  } tls_tqlim_t;

endpackage

// File: core/tls_core.sv
`timescale 1ns/1ps
module tls_core #(
  parameter int STALL_CYCLES = tls_pkg::STALL_CYC
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire tls_pkg::tls_method_t method_i,
  input  wire tls_pkg::tls_tqlim_t  tq_const_i,
  input  wire tls_pkg::tls_ain_t    ain1_i,
  input  wire tls_pkg::tls_ain_t    ain2_i,
  input  wire logic                 torque_fwd_i,
  input  wire logic                 regen_i,
  input  wire logic [9:0]           torque_dem_i,
  input  wire logic [1:0]           run_stall_select_i,
  input  wire logic                 run_stall_select_we_i,
  input  wire logic [9:0]           run_stall_level_i,
  input  wire logic                 run_stall_level_we_i,
  input  wire logic [9:0]           out_current_i,
  input  wire logic [15:0]          decel_time_one_i,
  input  wire logic [15:0]          decel_time_two_i,
  output logic [9:0]                tq_limit_o,
  output logic                      tq_clamp_o,
  output logic                      speed_ctrl_hold_o,
  output logic [1:0]                ch1_mode_o,
  output logic [1:0]                ch2_mode_o,
  output logic                      stall_decel_o,
  output logic                      stall_accel_o,
  output logic [15:0]               stall_decel_time_o,
  output logic [9:0]                stall_level_o
);

  // Elaboration check: the run counter needs at least one edge of overcurrent
  if (STALL_CYCLES < 1) begin : g_bad_stall_cycles
    $error("STALL_CYCLES must be at least 1");
  end

  // ==========================================================================
  // Helpers
  // Analog to percent: sample scaled by gain plus bias
  function automatic logic [9:0] ain_pct(input tls_pkg::tls_ain_t a);
    logic [23:0] p;
    logic [11:0] s;
    p = 24'(a.value) * 24'(a.gain) / 24'(tls_pkg::ADC_FS);
    s = 12'(p) + 12'(a.bias);
    return (s > 12'(tls_pkg::TQ_FULL)) ? tls_pkg::TQ_FULL : s[9:0];
  endfunction

  function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  // ==========================================================================
  // Torque limit selection
  logic       vec;
  logic [9:0] ain1_pct, ain2_pct, lim_pos, lim_neg, lim_rg, q_lim, lim_nxt;
  logic       clamp_nxt;
  logic [9:0] tq_limit_r;
  logic       tq_clamp_r;

  always_comb begin
    vec = (method_i == tls_pkg::TLS_OLV1) || (method_i == tls_pkg::TLS_FLUX) ||
          (method_i == tls_pkg::TLS_OLV2);
    ain1_pct = ain_pct(ain1_i);
    ain2_pct = ain_pct(ain2_i);
    lim_pos = tls_pkg::TQ_FULL;
    lim_neg = tls_pkg::TQ_FULL;
    lim_rg  = tls_pkg::TQ_FULL;
    if (vec) begin
      if (ain1_i.func == tls_pkg::FN_POS_TQ || ain1_i.func == tls_pkg::FN_BOTH_TQ)
        lim_pos = min10(lim_pos, ain1_pct);
      if (ain2_i.func == tls_pkg::FN_POS_TQ || ain2_i.func == tls_pkg::FN_BOTH_TQ)
        lim_pos = min10(lim_pos, ain2_pct);
      if (ain1_i.func == tls_pkg::FN_NEG_TQ || ain1_i.func == tls_pkg::FN_BOTH_TQ)
        lim_neg = min10(lim_neg, ain1_pct);
      if (ain2_i.func == tls_pkg::FN_NEG_TQ || ain2_i.func == tls_pkg::FN_BOTH_TQ)
        lim_neg = min10(lim_neg, ain2_pct);
      if (ain1_i.func == tls_pkg::FN_REGEN_TQ)
        lim_rg = min10(lim_rg, ain1_pct);
      if (ain2_i.func == tls_pkg::FN_REGEN_TQ)
        lim_rg = min10(lim_rg, ain2_pct);
    end
    case ({torque_fwd_i, regen_i})
      2'b10:   q_lim = tq_const_i.fwd_drive;
      2'b00:   q_lim = tq_const_i.rev_drive;
      2'b11:   q_lim = tq_const_i.fwd_regen;
      default: q_lim = tq_const_i.rev_regen;
    endcase
    // forward limit follows torque sign, even in regen
    lim_nxt = min10(q_lim, torque_fwd_i ? lim_pos : lim_neg);
    if (regen_i)
      lim_nxt = min10(lim_nxt, lim_rg);
    clamp_nxt = vec && (torque_dem_i >= lim_nxt);
  end

  // integer percent path well inside 5 percent
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tq_limit_r <= tls_pkg::TQ_FULL;
      tq_clamp_r <= 1'b0;
    end else begin
      tq_limit_r <= lim_nxt;
      tq_clamp_r <= clamp_nxt;
    end
  end

  // ==========================================================================
  // Stall settings and analog mode
  logic [1:0] sel_r, sel_nxt;
  logic [9:0] lvl_r, lvl_nxt;

  // Out-of-range writes are ignored rather than clipped
  always_comb begin
    sel_nxt = sel_r;
    lvl_nxt = lvl_r;
    if (run_stall_select_we_i && run_stall_select_i <= 2'h2)
      sel_nxt = run_stall_select_i;
    if (run_stall_level_we_i && run_stall_level_i >= tls_pkg::LVL_MIN &&
        run_stall_level_i <= tls_pkg::LVL_MAX)
      lvl_nxt = run_stall_level_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel_r      <= tls_pkg::SEL_RESET;
      lvl_r      <= tls_pkg::LVL_RESET;
      ch1_mode_o <= tls_pkg::CH1_MODE_RESET;
      ch2_mode_o <= tls_pkg::CH2_MODE_RESET;
    end else begin
      sel_r      <= sel_nxt;
      lvl_r      <= lvl_nxt;
      ch1_mode_o <= ch1_mode_o;
      ch2_mode_o <= ch2_mode_o;
    end
  end

  // ==========================================================================
  // Running stall prevention
  tls_pkg::tls_state_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [9:0]  eff_lvl;
  logic        en;

  always_comb begin
    // V/f methods only; needs select 1 or 2
    en = ((method_i == tls_pkg::TLS_VF) || (method_i == tls_pkg::TLS_VF_PG)) &&
         (sel_r != 2'h0);
    // function 8 channels; smaller level wins
    eff_lvl = lvl_r;
    if (ain1_i.func == tls_pkg::FN_STALL_LVL)
      eff_lvl = min10(eff_lvl, ain1_pct);
    if (ain2_i.func == tls_pkg::FN_STALL_LVL)
      eff_lvl = min10(eff_lvl, ain2_pct);
    st_nxt  = st_r;
    cnt_nxt = 32'h0000_0000;
    if (!en) begin
      st_nxt = tls_pkg::TLS_ST_RUN;
    end else begin
      case (st_r)
        tls_pkg::TLS_ST_RUN, tls_pkg::TLS_ST_ACCEL: begin
          if (out_current_i > eff_lvl) begin
            cnt_nxt = cnt_r + 32'h0000_0001;
            if (cnt_r + 32'h0000_0001 >= 32'(STALL_CYCLES))
              st_nxt = tls_pkg::TLS_ST_DECEL;
          end else if (st_r == tls_pkg::TLS_ST_ACCEL) begin
            st_nxt = tls_pkg::TLS_ST_RUN;  // Frequency loop ends it; one pass
          end
        end
        tls_pkg::TLS_ST_DECEL: begin
          // resume at level minus 2 percent
          // One spare bit: near full scale the sum would wrap and resume early
          if ({1'b0, out_current_i} + {1'b0, tls_pkg::HYST_PCT} <= {1'b0, eff_lvl})
            st_nxt = tls_pkg::TLS_ST_ACCEL;
        end
        default: st_nxt = tls_pkg::TLS_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r  <= tls_pkg::TLS_ST_RUN;
      cnt_r <= 32'h0000_0000;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Registered outputs
  logic        dec_nxt;
  logic        acc_nxt;
  logic [15:0] dt_nxt;

  // Output next values; flags follow st_nxt so they match the state register
  always_comb begin
    dec_nxt = (st_nxt == tls_pkg::TLS_ST_DECEL);
    acc_nxt = (st_nxt == tls_pkg::TLS_ST_ACCEL);
    dt_nxt  = (sel_r == 2'h2) ? decel_time_two_i : decel_time_one_i;
  end

  // Output flops only register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stall_decel_o      <= 1'b0;
      stall_accel_o      <= 1'b0;
      stall_decel_time_o <= 16'h0000;
      stall_level_o      <= tls_pkg::LVL_RESET;
      speed_ctrl_hold_o  <= 1'b0;
    end else begin
      stall_decel_o      <= dec_nxt;
      stall_accel_o      <= acc_nxt;
      stall_decel_time_o <= dt_nxt;
      stall_level_o      <= eff_lvl;
      speed_ctrl_hold_o  <= clamp_nxt;
    end
  end

  assign tq_limit_o = tq_limit_r;
  assign tq_clamp_o = tq_clamp_r;

endmodule

// File: verification/tls_core_props.sv
`timescale 1ns/1ps
module tls_core_props #(
  parameter int STALL_CYCLES = tls_pkg::STALL_CYC
) (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire tls_pkg::tls_method_t method_i,
  input wire tls_pkg::tls_tqlim_t  tq_const_i,
  input wire logic                 torque_fwd_i,
  input wire logic                 regen_i,
  input wire logic [9:0]           torque_dem_i,
  input wire logic [9:0]           out_current_i,
  input wire logic [9:0]           tq_limit_o,
  input wire logic                 tq_clamp_o,
  input wire logic                 speed_ctrl_hold_o,
  input wire logic [1:0]           ch1_mode_o,
  input wire logic [1:0]           ch2_mode_o,
  input wire logic                 stall_decel_o,
  input wire logic                 stall_accel_o,
  input wire logic [9:0]           stall_level_o
);
  // ==========================================================================
  // Helpers
  logic [31:0] ovr_cnt_r;
  logic [31:0] ovr_cnt_nxt;
  logic        vf_w;
  logic [9:0]  quad_w;
  // Method class and quadrant constant
  assign vf_w = (method_i == tls_pkg::TLS_VF) || (method_i == tls_pkg::TLS_VF_PG);
  assign quad_w = torque_fwd_i ? (regen_i ? tq_const_i.fwd_regen : tq_const_i.fwd_drive)
                               : (regen_i ? tq_const_i.rev_regen : tq_const_i.rev_drive);
  // Run length of overcurrent; lower bound only, level lag tolerated
  always_comb begin
    ovr_cnt_nxt = (out_current_i > stall_level_o) ? ovr_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk_i) begin
    ovr_cnt_r <= rst_i ? 32'h0 : ovr_cnt_nxt;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Properties
  AST_HOLD_IS_CLAMP: assert property (speed_ctrl_hold_o == tq_clamp_o)
    else $error("speed hold differs from clamp");
  AST_MODES: assert property (ch1_mode_o == tls_pkg::CH1_MODE_RESET && ch2_mode_o == 2'h0)
    else $error("channel modes wrong");
  AST_VF_NO_CLAMP: assert property (vf_w |=> !tq_clamp_o)
    else $error("clamp in scalar method");
  AST_VF_CONST: assert property (vf_w |=> tq_limit_o == $past(quad_w))
    else $error("limit not quadrant constant");
  AST_CLAMP_REL: assert property (!vf_w |=> tq_clamp_o == ($past(torque_dem_i) >= tq_limit_o))
    else $error("clamp not tied to demand");
  AST_VEC_NO_STALL: assert property (!vf_w |=> !stall_decel_o && !stall_accel_o)
    else $error("stall active in vector method");
  AST_DECEL_AFTER: assert property ($rose(stall_decel_o) |-> $past(ovr_cnt_r) >= STALL_CYCLES - 1)
    else $error("decel too early");
  AST_RESUME: assert property (stall_decel_o && vf_w &&
      ({1'b0, out_current_i} + 11'h002 <= {1'b0, stall_level_o}) |=> stall_accel_o && !stall_decel_o)
    else $error("no resume after current fell");
  AST_ACCEL_END: assert property (stall_accel_o && vf_w && out_current_i <= stall_level_o |=> !stall_accel_o)
    else $error("accel phase did not end");
  CV_DECEL: cover property ($rose(stall_decel_o));
  CV_ACCEL: cover property ($rose(stall_accel_o));
  CV_CLAMP: cover property (tq_clamp_o && !vf_w);
endmodule

bind tls_core tls_core_props #(.STALL_CYCLES(STALL_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .method_i(method_i), .tq_const_i(tq_const_i),
  .torque_fwd_i(torque_fwd_i), .regen_i(regen_i), .torque_dem_i(torque_dem_i),
  .out_current_i(out_current_i), .tq_limit_o(tq_limit_o), .tq_clamp_o(tq_clamp_o),
  .speed_ctrl_hold_o(speed_ctrl_hold_o), .ch1_mode_o(ch1_mode_o), .ch2_mode_o(ch2_mode_o),
  .stall_decel_o(stall_decel_o), .stall_accel_o(stall_accel_o), .stall_level_o(stall_level_o));

// File: verification/tls_motor_model.sv
`timescale 1ns/1ps
module tls_motor_model (
  input  wire logic       ref_clk_i,
  input  wire logic       decel_i,
  input  wire logic [9:0] load_i,
  output logic      [9:0] cur_o = 10'h000
);
  // Slowing down sheds half the load; otherwise current tracks load
  always_ff @(posedge ref_clk_i) begin
    cur_o <= decel_i ? {1'b0, load_i[9:1]} : load_i;
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {int due; int k; logic [15:0] v;} tls_note_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  tls_pkg::tls_method_t method_i = tls_pkg::TLS_VF;
  tls_pkg::tls_tqlim_t tq = '0;
  tls_pkg::tls_ain_t ain1 = '0;
  tls_pkg::tls_ain_t ain2 = '0;
  logic fwd = 1'b0, rg = 1'b0, swe = 1'b0, lwe = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [9:0] dem = '0, lvl = '0, load = '0, cur, lim, o_lim, o_lvl;
  logic o_clp, o_hld, o_dec, o_acc, app;
  logic [1:0] o_m1, o_m2;
  logic [15:0] o_dt, got, s = 16'h672E, dt1 = 16'h0123, dt2 = 16'h0456;
  logic [4:0] codes [4] = '{tls_pkg::FN_POS_TQ, tls_pkg::FN_NEG_TQ, tls_pkg::FN_REGEN_TQ,
                            tls_pkg::FN_BOTH_TQ};
  string nm [8] = '{"tq_limit", "clamp", "hold", "decel", "accel", "decel_time", "level", "modes"};
  int cyc = 0, fails = 0, n_checks = 0, ana, c;
  tls_note_t q[$];
  // ==========================================================================
  // Clock, design, far side
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  tls_core #(.STALL_CYCLES(20)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .method_i(method_i),
    .tq_const_i(tq), .ain1_i(ain1), .ain2_i(ain2), .torque_fwd_i(fwd), .regen_i(rg),
    .torque_dem_i(dem), .run_stall_select_i(sel), .run_stall_select_we_i(swe),
    .run_stall_level_i(lvl), .run_stall_level_we_i(lwe), .out_current_i(cur),
    .decel_time_one_i(dt1), .decel_time_two_i(dt2), .tq_limit_o(o_lim), .tq_clamp_o(o_clp),
    .speed_ctrl_hold_o(o_hld), .ch1_mode_o(o_m1), .ch2_mode_o(o_m2), .stall_decel_o(o_dec),
    .stall_accel_o(o_acc), .stall_decel_time_o(o_dt), .stall_level_o(o_lvl));
  tls_motor_model motor (.ref_clk_i(ref_clk_i), .decel_i(o_dec), .load_i(load), .cur_o(cur));
  // ==========================================================================
  // Helpers
  function automatic logic [15:0] nx(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic ex(int d, int k, logic [15:0] v);
    q.push_back('{cyc + d, k, v});
  endtask
  task automatic conclude();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Overload held long enough, then shed; resume timing follows
  task automatic stall(logic [15:0] t, logic on);
    load = 10'h078;
    ex(20, 3, 16'h0000);
    ex(21, 3, {15'h0, on});
    if (on) begin
      ex(21, 5, t);
      ex(23, 4, 16'h0001);
      ex(24, 4, 16'h0000);
    end
    repeat (24) @(negedge ref_clk_i);
    load = '0;
    repeat (8) @(negedge ref_clk_i);
  endtask
  // ==========================================================================
  // Scoreboard: every due note, oldest first, against settled outputs
  always @(posedge ref_clk_i) begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      case (q[0].k)
        0: got = {6'h00, o_lim};
        1: got = {15'h0, o_clp};
        2: got = {15'h0, o_hld};
        3: got = {15'h0, o_dec};
        4: got = {15'h0, o_acc};
        5: got = o_dt;
        6: got = {6'h00, o_lvl};
        default: got = {12'h000, o_m1, o_m2};
      endcase
      n_checks++;
      if (got !== q[0].v) begin
        fails++;
        $display("MISMATCH %s exp=%h got=%h", nm[q[0].k], q[0].v, got);
      end
      void'(q.pop_front());
    end
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
  // ==========================================================================
  // Stimulus
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    ex(1, 6, 16'h00A0);
    ex(1, 7, 16'h0004);
    // Every method, code and quadrant; full scale every eighth pass
    for (int i = 0; i < 80; i++) begin
      s = nx(s);
      c = (i / 4) % 4;
      method_i = tls_pkg::tls_method_t'(i / 16);
      {fwd, rg} = 2'(i);
      ain1.func = codes[c];
      ain1.gain = 10'h096;
      ain1.value = (i % 8 == 0) ? 12'hFFF : s[11:0];
      tq = {2'h0, s[7:0], 2'h0, s[15:8], 2'h0, s[9:2], 2'h0, s[13:6]};
      dem = {2'h0, s[12:5]};
      ana = (ain1.value * 150) / 4095;
      lim = fwd ? (rg ? tq.fwd_regen : tq.fwd_drive) : (rg ? tq.rev_regen : tq.rev_drive);
      app = (c == 0 && fwd) || (c == 1 && !fwd) || (c == 2 && rg) || c == 3;
      if (i >= 32 && app && ana < lim) lim = 10'(ana);
      ex(1, 0, {6'h00, lim});
      ex(1, 1, {15'h0, i >= 32 && dem >= lim});
      ex(1, 2, {15'h0, i >= 32 && dem >= lim});
      @(negedge ref_clk_i);
    end
    method_i = tls_pkg::TLS_VF;
    ain1.func = '0;
    dem = '0;
    lvl = 10'h064;
    lwe = 1'b1;
    @(negedge ref_clk_i);
    lvl = 10'h014;
    sel = 2'h3;
    swe = 1'b1;
    @(negedge ref_clk_i);
    lwe = 1'b0;
    swe = 1'b0;
    ex(2, 6, 16'h0064);
    stall(dt1, 1'b1);
    sel = 2'h2;
    swe = 1'b1;
    @(negedge ref_clk_i);
    swe = 1'b0;
    stall(dt2, 1'b1);
    // Both channels as stall level: channel two with bias is lower and wins
    ain1.func = tls_pkg::FN_STALL_LVL;
    ain1.value = 12'hFFF;
    ain2.func = tls_pkg::FN_STALL_LVL;
    ain2.gain = 10'h064;
    ain2.bias = 10'h00A;
    ain2.value = 12'h800;
    ex(2, 6, 16'h003C);
    repeat (3) @(negedge ref_clk_i);
    ain2.func = '0;
    ex(2, 6, 16'h0064);
    repeat (3) @(negedge ref_clk_i);
    ain1.func = '0;
    method_i = tls_pkg::TLS_FLUX;
    stall(dt2, 1'b0);
    method_i = tls_pkg::TLS_VF;
    sel = 2'h0;
    swe = 1'b1;
    @(negedge ref_clk_i);
    swe = 1'b0;
    stall(dt2, 1'b0);
    // Mid-run reset: selection and level go back to their reset values
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    ex(1, 6, 16'h00A0);
    lvl = 10'h064;
    lwe = 1'b1;
    @(negedge ref_clk_i);
    lwe = 1'b0;
    stall(dt1, 1'b1);
    conclude();
  end
endmodule
